// ### shared/drs_pkg.sv
// constants, field layout and reset values of the dimmer colour/staircase block
// assumes pclk at 100 MHz and telegram strobes already decoded on pclk
// ----------------------------------------
// Operation
// ----------------------------------------
// Operation
// - accept 3-byte colour value when enabled
// - red selection uses first byte
// - green selection uses second byte
// - blue selection uses third byte
// - white selection uses smallest byte
// - brightness selection uses largest byte
// - clamp below lower limit, default 0
// - clamp above upper limit, default 255
// - colour fades brighter/darker, 4 s each
// - day on ON, night on OFF
// - day mode after every restart
// - staircase ON dims to day/night on-value
// - staircase switch-on fade, default 1 s
// - delay end dims to off or orientation
// - stay-on: OFF telegram starts the delay
// - start-delay: ON starts delay at once
// - retrigger decides whether further ONs restart
// - retrigger decides whether further OFFs restart
// - orientation duration disabled, steps, or unlimited
// - orientation dims to orientation level, 20
// - orientation fade time, default 10 s
// - active lock overrides staircase control
// - OFF reaction chosen among five options
// - ending dims to mode off-value, off fade
package drs_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_IN_NS      = 1000000;
	localparam int unsigned TICK_CYCLES   = MS_IN_NS / CLK_PERIOD_NS;
	localparam logic [9:0]  MS_PER_S      = 10'h3E8;
	localparam logic [7:0]  FULL_SWEEP    = 8'hFF;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_LIMIT  = 8'h04;
	localparam logic [7:0] REG_LEVELS = 8'h08;
	localparam logic [7:0] REG_ORIENT = 8'h0C;
	localparam logic [7:0] REG_FRGB   = 8'h10;
	localparam logic [7:0] REG_FSTAIR = 8'h14;
	localparam logic [7:0] REG_FOFF   = 8'h18;
	localparam logic [7:0] REG_DELAY  = 8'h1C;
	localparam logic [7:0] REG_STATUS = 8'h20;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int CTRL_RGB_EN = 0;
	localparam int CTRL_USE    = 1;
	localparam int CTRL_ONR    = 4;
	localparam int CTRL_RETRIG = 5;
	localparam int CTRL_OFFR   = 6;
	localparam int CTRL_ORI    = 9;

	localparam logic [2:0] USE_RED   = 3'h0;
	localparam logic [2:0] USE_GREEN = 3'h1;
	localparam logic [2:0] USE_BLUE  = 3'h2;
	localparam logic [2:0] USE_WHITE = 3'h3;
	localparam logic [2:0] USE_BRIGHT = 3'h4;

	localparam logic [2:0] OFFR_IGNORE = 3'h0;
	localparam logic [2:0] OFFR_OFF    = 3'h1;
	localparam logic [2:0] OFFR_DELAY  = 3'h2;
	localparam logic [2:0] OFFR_ORI    = 3'h3;
	localparam logic [2:0] OFFR_ORI2   = 3'h4;

	localparam logic [3:0] ORI_NONE = 4'h0;
	localparam logic [3:0] ORI_UNL  = 4'hE;
	localparam logic [15:0] ORI_SEC [0:15] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005,
		16'h000A, 16'h001E, 16'h003C, 16'h0078, 16'h012C, 16'h0258, 16'h04B0,
		16'h0708, 16'h0E10, 16'h1C20, 16'h0000, 16'h0000};

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	// colour enabled, brightness use, start-delay on ON, 30 s orientation
	localparam logic [31:0] CTRL_RST   = 32'h0000_0A19;
	localparam logic [15:0] LIMIT_RST  = 16'hFF00;
	localparam logic [31:0] LEVELS_RST = 32'h0A00_3264;
	localparam logic [7:0]  ORIENT_RST = 8'h14;
	localparam logic [31:0] FRGB_RST   = 32'h0004_0004;
	localparam logic [31:0] FSTAIR_RST = 32'h000A_0001;
	localparam logic [15:0] FOFF_RST   = 16'h0004;
	localparam logic [31:0] DELAY_RST  = 32'h0000_0258;

	typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_DELAY, ST_ORIENT} drs_stair_t;

endpackage

// ### rtl/drs_fader.sv
// level ramp: steps one level whenever 255 units per ms outrun the fade time
// assumes a one-cycle ms tick on the same clock
`timescale 1ns/1ps
module drs_fader import drs_pkg::*; (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       tick,
	input  wire logic       load,
	input  wire logic [7:0] target,
	input  wire logic [15:0] fade_sec,
	// result
	output logic [7:0]      level,
	output logic            busy
);
	typedef struct packed {
		logic [7:0]  lvl;
		logic [7:0]  tgt;
		logic [25:0] thr;
		logic [25:0] acc;
	} drs_fade_t;

	drs_fade_t s_r, s_nxt;
	logic [25:0] sum;

	always_comb begin
		s_nxt = s_r;
		sum = s_r.acc + 26'(FULL_SWEEP);
		if (load) begin
			s_nxt.tgt = target;
			s_nxt.thr = 26'(fade_sec) * 26'(MS_PER_S);
			s_nxt.acc = 26'h0;
		end else if (s_r.lvl != s_r.tgt) begin
			if (s_r.thr == 26'h0) begin
				s_nxt.lvl = s_r.tgt;
			end else if (tick) begin
				// remainder carries, so a partial sweep takes its share exactly
				if (sum >= s_r.thr) begin
					s_nxt.acc = sum - s_r.thr;
					s_nxt.lvl = (s_r.tgt > s_r.lvl) ? s_r.lvl + 8'h01 : s_r.lvl - 8'h01;
				end else begin
					s_nxt.acc = sum;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.lvl;
	assign busy  = s_r.lvl != s_r.tgt;
endmodule

// ### rtl/drs_timer.sv
// seconds down-counter driven by the ms tick; one-cycle pulse on expiry
// assumes load and stop never coincide with a wanted expiry
`timescale 1ns/1ps
module drs_timer import drs_pkg::*; (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// control
	input  wire logic        tick,
	input  wire logic        load,
	input  wire logic        stop,
	input  wire logic [31:0] secs,
	// result
	output logic             expired
);
	typedef struct packed {
		logic        run;
		logic [31:0] sec;
		logic [9:0]  ms;
		logic        exp;
	} drs_tmr_t;

	drs_tmr_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.exp = 1'b0;
		if (load) begin
			s_nxt.run = 1'b1;
			s_nxt.sec = secs;
			s_nxt.ms  = 10'h000;
		end else if (stop) begin
			s_nxt.run = 1'b0;
		end else if (s_r.run && tick) begin
			if (s_r.ms == MS_PER_S - 10'h001) begin
				s_nxt.ms = 10'h000;
				if (s_r.sec <= 32'h0000_0001) begin
					s_nxt.run = 1'b0;
					s_nxt.exp = 1'b1;
				end else begin
					s_nxt.sec = s_r.sec - 32'h0000_0001;
				end
			end else begin
				s_nxt.ms = s_r.ms + 10'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign expired = s_r.exp;
endmodule

// ### rtl/drs_core.sv
// dimmer channel control: colour-value source and staircase light with orientation phase
// assumes telegram strobes and the lock level come from logic on pclk
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module drs_core import drs_pkg::*; #(
	parameter int unsigned TICK = TICK_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// telegrams from the bus stack
	input  wire logic        rgb_valid,
	input  wire logic [23:0] rgb_value,
	input  wire logic        stair_valid,
	input  wire logic        stair_value,
	input  wire logic        dn_valid,
	input  wire logic        dn_value,
	// lock function
	input  wire logic        lock_active,
	// dimmer side
	output logic [7:0]       dim_level,
	output logic             stair_active,
	output logic             night_mode
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] limit;
		logic [31:0] levels;
		logic [7:0]  orl;
		logic [31:0] frgb;
		logic [31:0] fstair;
		logic [15:0] foff;
		logic [31:0] delay;
		logic        night;
		drs_stair_t  stair;
		logic        act;
		logic [7:0]  tgt;
		logic [15:0] fsec;
		logic        fload;
		logic        tload;
		logic        tstop;
		logic [31:0] tsec;
		logic [31:0] pre;
		logic        tick;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
	} drs_state_t;

	drs_state_t s_r, s_nxt;

	logic [7:0] level;
	logic       busy;
	logic       expired;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [7:0] c_r, c_g, c_b, pick, clamped;
	logic [7:0] on_lvl, off_lvl;
	logic [2:0] use_sel, offr;
	logic [3:0] ori_sel;
	logic       onr, retrig, wr_en;
	logic       do_on, do_dly, do_ori, do_off;
	logic [31:0] rd;

	always_comb begin
		c_r = rgb_value[23:16];
		c_g = rgb_value[15:8];
		c_b = rgb_value[7:0];
		use_sel = s_r.ctrl[CTRL_USE +: 3];
		onr     = s_r.ctrl[CTRL_ONR];
		retrig  = s_r.ctrl[CTRL_RETRIG];
		offr    = s_r.ctrl[CTRL_OFFR +: 3];
		ori_sel = s_r.ctrl[CTRL_ORI +: 4];
		case (use_sel)
			USE_RED: begin
				pick = c_r;
			end
			USE_GREEN: begin
				pick = c_g;
			end
			USE_BLUE: begin
				pick = c_b;
			end
			USE_WHITE: begin
				pick = (c_r < c_g) ? c_r : c_g;
				pick = (c_b < pick) ? c_b : pick;
			end
			default: begin
				pick = (c_r > c_g) ? c_r : c_g;
				pick = (c_b > pick) ? c_b : pick;
			end
		endcase
		// limits follow the pick; crossed limits give the upper one for picks above it, else the lower one
		clamped = pick;
		if (pick < s_r.limit[7:0]) begin
			clamped = s_r.limit[7:0];
		end
		if (pick > s_r.limit[15:8]) begin
			clamped = s_r.limit[15:8];
		end
		on_lvl  = s_r.night ? s_r.levels[15:8] : s_r.levels[7:0];
		off_lvl = s_r.night ? s_r.levels[31:24] : s_r.levels[23:16];
	end

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	always_comb begin
		case (paddr)
			// sampled in the setup cycle; the access cycle shows the registered copy
			REG_CTRL:   rd = {19'h0, s_r.ctrl[12:0]};
			REG_LIMIT:  rd = {16'h0, s_r.limit};
			REG_LEVELS: rd = s_r.levels;
			REG_ORIENT: rd = {24'h0, s_r.orl};
			REG_FRGB:   rd = s_r.frgb;
			REG_FSTAIR: rd = s_r.fstair;
			REG_FOFF:   rd = {16'h0, s_r.foff};
			REG_DELAY:  rd = s_r.delay;
			// status: level, target, mode, state and fading flag, low bits up
			REG_STATUS: rd = {12'h0, busy, s_r.stair, s_r.night, s_r.tgt, level};
			default:    rd = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.fload = 1'b0;
		s_nxt.tload = 1'b0;
		s_nxt.tstop = 1'b0;
		s_nxt.tick  = 1'b0;
		do_on  = 1'b0;
		do_dly = 1'b0;
		do_ori = 1'b0;
		do_off = 1'b0;

		// ms time base shared by fader and timer
		if (s_r.pre >= 32'(TICK - 1)) begin
			s_nxt.pre  = 32'h0000_0000;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.pre = s_r.pre + 32'h0000_0001;
		end

		// apb: answer registered in the setup cycle, so one wait-free access phase
		s_nxt.ready = psel && !penable;
		s_nxt.rdata = rd;
		s_nxt.err   = psel && !penable && (paddr[1:0] != 2'h0 || paddr > REG_STATUS);
		// a write lands only on the answered access edge, never on a refused one
		wr_en = psel && penable && pwrite && s_r.ready && !s_r.err;
		if (wr_en) begin
			case (paddr)
				REG_CTRL:   s_nxt.ctrl   = {19'h0, pwdata[12:0]};
				REG_LIMIT:  s_nxt.limit  = pwdata[15:0];
				REG_LEVELS: s_nxt.levels = pwdata;
				REG_ORIENT: s_nxt.orl    = pwdata[7:0];
				REG_FRGB:   s_nxt.frgb   = pwdata;
				REG_FSTAIR: s_nxt.fstair = pwdata;
				REG_FOFF:   s_nxt.foff   = pwdata[15:0];
				REG_DELAY:  s_nxt.delay  = pwdata;
				default: begin
				end
			endcase
		end

		// day on ON, night on OFF
		if (dn_valid) begin
			s_nxt.night = !dn_value;
		end

		// staircase decisions: the lock first, then ON, then OFF telegrams
		// a colour value only lands when no staircase action, from telegram or timer, fires
		if (lock_active) begin
			// lock overrides the staircase; it drops back to idle and its timer halts
			s_nxt.stair = ST_IDLE;
			s_nxt.tstop = 1'b1;
		end else if (stair_valid && stair_value) begin
			case (s_r.stair)
				ST_IDLE, ST_ORIENT: begin
					do_on  = 1'b1;
					do_dly = onr;
				end
				ST_ON: begin
					do_on = 1'b1;
				end
				ST_DELAY: begin
					if (!onr) begin
						do_on = 1'b1;
					end else if (retrig) begin
						do_on  = 1'b1;
						do_dly = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end else if (stair_valid && !stair_value) begin
			case (s_r.stair)
				ST_ON: begin
					do_dly = 1'b1;
				end
				ST_DELAY: begin
					case (offr)
						OFFR_OFF: do_off = 1'b1;
						OFFR_DELAY: do_dly = retrig;
						OFFR_ORI, OFFR_ORI2: do_ori = 1'b1;
						default: do_dly = !onr && retrig;
					endcase
				end
				ST_ORIENT: begin
					// second OFF in the two-step option ends the light
					do_off = (offr == OFFR_OFF) || (offr == OFFR_ORI2);
				end
				default: begin
				end
			endcase
		end
		// an expiry beside a telegram that does nothing must not be lost
		if (expired && !lock_active && !(do_on || do_dly || do_ori || do_off)) begin
			case (s_r.stair)
				ST_DELAY: begin
					do_ori = 1'b1;
				end
				ST_ORIENT: begin
					do_off = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// disabled orientation goes straight to the off value
		if (do_ori && ori_sel == ORI_NONE) begin
			do_ori = 1'b0;
			do_off = 1'b1;
		end

		if (do_off) begin
			s_nxt.stair = ST_IDLE;
			s_nxt.tstop = 1'b1;
			s_nxt.fload = 1'b1;
			s_nxt.tgt   = off_lvl;
			s_nxt.fsec  = s_r.foff;
		end else if (do_ori) begin
			s_nxt.stair = ST_ORIENT;
			s_nxt.fload = 1'b1;
			s_nxt.tgt   = s_r.orl;
			s_nxt.fsec  = s_r.fstair[31:16];
			if (ori_sel == ORI_UNL) begin
				// no time limit: timer parked, only a telegram or the lock ends it
				s_nxt.tstop = 1'b1;
			end else begin
				s_nxt.tload = 1'b1;
				s_nxt.tsec  = {16'h0, ORI_SEC[ori_sel]};
			end
		end else if (do_on) begin
			s_nxt.fload = 1'b1;
			s_nxt.tgt   = on_lvl;
			s_nxt.fsec  = s_r.fstair[15:0];
			s_nxt.stair = do_dly ? ST_DELAY : ST_ON;
			s_nxt.tload = do_dly;
			s_nxt.tstop = !do_dly;
			s_nxt.tsec  = s_r.delay;
		end else if (do_dly) begin
			s_nxt.stair = ST_DELAY;
			s_nxt.tload = 1'b1;
			s_nxt.tsec  = s_r.delay;
		end else if (rgb_valid && s_r.ctrl[CTRL_RGB_EN]) begin
			// colour telegram loses to a staircase event in the same cycle
			s_nxt.fload = 1'b1;
			s_nxt.tgt   = clamped;
			s_nxt.fsec  = (clamped > level) ? s_r.frgb[15:0] : s_r.frgb[31:16];
		end
		s_nxt.act = s_nxt.stair != ST_IDLE;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// parameters come up at their defaults, runtime state cleared
			s_r        <= '0;
			s_r.ctrl   <= CTRL_RST;
			s_r.limit  <= LIMIT_RST;
			s_r.levels <= LEVELS_RST;
			s_r.orl    <= ORIENT_RST;
			s_r.frgb   <= FRGB_RST;
			s_r.fstair <= FSTAIR_RST;
			s_r.foff   <= FOFF_RST;
			s_r.delay  <= DELAY_RST;
			s_r.night  <= 1'b0;
			s_r.stair  <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// fader and delay timer
	// ----------------------------------------
	// both share the registered ms tick, so fade steps and delay seconds stay in phase
	drs_fader u_fader (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (s_r.tick),
		.load     (s_r.fload),
		.target   (s_r.tgt),
		.fade_sec (s_r.fsec),
		.level    (level),
		.busy     (busy)
	);

	drs_timer u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (s_r.tick),
		.load     (s_r.tload),
		.stop     (s_r.tstop),
		.secs     (s_r.tsec),
		.expired  (expired)
	);

	assign prdata       = s_r.rdata;
	assign pready       = s_r.ready;
	assign pslverr      = s_r.err;
	assign dim_level    = level;
	assign stair_active = s_r.act;
	assign night_mode   = s_r.night;
endmodule

// ### tb/drs_core_props.sv
// checker for the dimmer channel: apb timing, day/night and staircase relations
// assumes it is bound to drs_core and sees only its ports
`timescale 1ns/1ps
module drs_core_props import drs_pkg::*; #(
	parameter int unsigned TICK = TICK_CYCLES
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// telegrams and lock
	input wire logic        stair_valid,
	input wire logic        stair_value,
	input wire logic        dn_valid,
	input wire logic        dn_value,
	input wire logic        lock_active,
	// dimmer side
	input wire logic        stair_active,
	input wire logic        night_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_bad;
		s_setup ##0 (paddr[1:0] != 2'h0 || paddr > 8'h20);
	endsequence
	sequence s_good;
		s_setup ##0 (paddr[1:0] == 2'h0 && paddr <= 8'h20);
	endsequence

	a_ready_setup: assert property (s_setup |=> pready)
		else $error("ready missing after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_bad: assert property (s_bad |=> pslverr && prdata == 32'h0000_0000)
		else $error("bad address not refused");
	a_err_good: assert property (s_good |=> !pslverr)
		else $error("mapped address refused");
	a_day_set: assert property (dn_valid && dn_value |-> ##[1:2] !night_mode)
		else $error("day telegram ignored");
	a_night_set: assert property (dn_valid && !dn_value |-> ##[1:2] night_mode)
		else $error("night telegram ignored");
	a_reset_day: assert property ($rose(presetn) |-> !night_mode)
		else $error("not in day mode after reset");
	a_lock_idle: assert property (lock_active |-> ##[0:2] !stair_active)
		else $error("staircase runs under lock");
	a_stair_on: assert property (stair_valid && stair_value && !lock_active |-> ##[1:2] stair_active)
		else $error("staircase did not start");
endmodule

bind drs_core drs_core_props #(.TICK(TICK)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .stair_valid(stair_valid),
	.stair_value(stair_value), .dn_valid(dn_valid), .dn_value(dn_value),
	.lock_active(lock_active), .stair_active(stair_active), .night_mode(night_mode)
);

// ### tb/drs_tele_src.sv
// group telegram senders: one-cycle strobes with their values
// assumes the bench calls its tasks; value lines show inverted data between telegrams
`timescale 1ns/1ps
module drs_tele_src (
	// clock
	input wire logic  pclk,
	// telegrams
	output logic        rgb_valid,
	output logic [23:0] rgb_value,
	output logic        stair_valid,
	output logic        stair_value,
	output logic        dn_valid,
	output logic        dn_value
);
	initial begin
		rgb_valid = 1'b0;
		rgb_value = 24'h000000;
		stair_valid = 1'b0;
		stair_value = 1'b0;
		dn_valid = 1'b0;
		dn_value = 1'b0;
	end
	// all three bytes travel together in one strobe
	task automatic send_rgb(input logic [23:0] v);
		@(posedge pclk);
		rgb_valid <= 1'b1;
		rgb_value <= v;
		@(posedge pclk);
		rgb_valid <= 1'b0;
		rgb_value <= ~v;
	endtask
	task automatic send_stair(input logic v);
		@(posedge pclk);
		stair_valid <= 1'b1;
		stair_value <= v;
		@(posedge pclk);
		stair_valid <= 1'b0;
		stair_value <= ~v;
	endtask
	task automatic send_dn(input logic v);
		@(posedge pclk);
		dn_valid <= 1'b1;
		dn_value <= v;
		@(posedge pclk);
		dn_valid <= 1'b0;
		dn_value <= ~v;
	endtask
endmodule

// ### tb/drs_core_bench.sv
// self-checking bench for drs_core: apb register access plus colour and staircase runs
// assumes TICK of 10, so one second is 10000 cycles
`timescale 1ns/1ps
module drs_core_bench import drs_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lock_active;
	logic [7:0]  paddr, dim_level;
	logic [31:0] pwdata, prdata, r;
	logic        rgb_valid, stair_valid, stair_value, dn_valid, dn_value, e;
	logic        stair_active, night_mode;
	logic [23:0] rgb_value;
	logic [31:0] rst_tab [0:7];
	logic [7:0]  sel_exp [0:4];
	int          miscompares, checked;

	drs_tele_src u_src (.pclk(pclk), .rgb_valid(rgb_valid), .rgb_value(rgb_value),
		.stair_valid(stair_valid), .stair_value(stair_value), .dn_valid(dn_valid),
		.dn_value(dn_value));
	drs_core #(.TICK(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rgb_valid(rgb_valid), .rgb_value(rgb_value),
		.stair_valid(stair_valid), .stair_value(stair_value), .dn_valid(dn_valid),
		.dn_value(dn_value), .lock_active(lock_active), .dim_level(dim_level),
		.stair_active(stair_active), .night_mode(night_mode));

	always #5 pclk = ~pclk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count here: only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic lvl(input logic [7:0] x, input logic act);
		chk({24'h0, dim_level}, {24'h0, x});
		chk({31'h0, stair_active}, {31'h0, act});
	endtask
	function automatic logic [31:0] ctrl(input logic [2:0] u, input logic onr,
		input logic [2:0] offr, input logic [3:0] ori);
		return {19'h0, ori, offr, 1'b0, onr, u, 1'b1};
	endfunction

	initial begin
		#950000;
		// a hang counts as a failure
		miscompares++;
		wrap_up();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
		pwdata = 32'h0; lock_active = 0; miscompares = 0; checked = 0;
		rst_tab = '{CTRL_RST, {16'h0, LIMIT_RST}, LEVELS_RST, {24'h0, ORIENT_RST},
			FRGB_RST, FSTAIR_RST, {16'h0, FOFF_RST}, DELAY_RST};
		sel_exp = '{8'h30, 8'h10, 8'h50, 8'h10, 8'h50};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk({31'h0, night_mode}, 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(r, rst_tab[i]);
		end
		apb(1'b0, REG_LIMIT, 32'h0);
		chk({24'h0, r[7:0]}, 32'h0);
		chk({24'h0, r[15:8]}, 32'hFF);
		apb(1'b0, 8'h24, 32'h0);
		chk({r[31:1], e}, 32'h1);
		apb(1'b1, 8'h02, 32'h1);
		chk({31'h0, e}, 32'h1);
		// colour component selection, instant fades
		apb(1'b1, REG_FRGB, 32'h0);
		for (int u = 0; u < 5; u++) begin
			apb(1'b1, REG_CTRL, ctrl(3'(u), 1'b1, OFFR_OFF, 4'h1));
			u_src.send_rgb(24'h301050);
			repeat (4) @(posedge pclk);
			lvl(sel_exp[u], 1'b0);
		end
		apb(1'b1, REG_CTRL, ctrl(USE_RED, 1'b1, OFFR_OFF, 4'h1) & 32'hFFFF_FFFE);
		u_src.send_rgb(24'h99_9999);
		repeat (4) @(posedge pclk);
		lvl(8'h50, 1'b0);
		apb(1'b1, REG_CTRL, ctrl(USE_RED, 1'b1, OFFR_OFF, 4'h1));
		apb(1'b1, REG_LIMIT, 32'h4020);
		u_src.send_rgb(24'h10FFFF);
		repeat (4) @(posedge pclk);
		lvl(8'h20, 1'b0);
		u_src.send_rgb(24'h900000);
		repeat (4) @(posedge pclk);
		lvl(8'h40, 1'b0);
		// full sweep with a one-second brighter fade
		apb(1'b1, REG_LIMIT, 32'hFF00);
		apb(1'b1, REG_FRGB, 32'h0000_0001);
		u_src.send_rgb(24'h00FFFF);
		u_src.send_rgb(24'hFF0000);
		repeat (5000) @(posedge pclk);
		chk({31'h0, (dim_level >= 8'h7C && dim_level <= 8'h83)}, 32'h1);
		repeat (5100) @(posedge pclk);
		lvl(8'hFF, 1'b0);
		// night staircase with orientation phase
		u_src.send_dn(1'b0);
		repeat (3) @(posedge pclk);
		chk({31'h0, night_mode}, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, r[16]}, 32'h1);
		apb(1'b1, REG_FSTAIR, 32'h0);
		apb(1'b1, REG_FOFF, 32'h0);
		apb(1'b1, REG_DELAY, 32'h1);
		u_src.send_stair(1'b1);
		repeat (4) @(posedge pclk);
		lvl(8'h32, 1'b1);
		repeat (9000) @(posedge pclk);
		lvl(8'h32, 1'b1);
		repeat (6000) @(posedge pclk);
		lvl(8'h14, 1'b1);
		repeat (10000) @(posedge pclk);
		lvl(8'h0A, 1'b0);
		u_src.send_dn(1'b1);
		repeat (3) @(posedge pclk);
		chk({31'h0, night_mode}, 32'h0);
		// off telegram switches off at once
		u_src.send_stair(1'b1);
		repeat (4) @(posedge pclk);
		lvl(8'h64, 1'b1);
		u_src.send_stair(1'b0);
		repeat (4) @(posedge pclk);
		lvl(8'h00, 1'b0);
		// stay-on: delay runs only after the off telegram
		apb(1'b1, REG_CTRL, ctrl(USE_RED, 1'b0, OFFR_DELAY, ORI_NONE));
		u_src.send_stair(1'b1);
		repeat (15000) @(posedge pclk);
		lvl(8'h64, 1'b1);
		u_src.send_stair(1'b0);
		repeat (5000) @(posedge pclk);
		lvl(8'h64, 1'b1);
		// a second OFF without retrigger must not restart the delay
		u_src.send_stair(1'b0);
		repeat (7000) @(posedge pclk);
		lvl(8'h00, 1'b0);
		// lock stops the staircase and holds the level
		apb(1'b1, REG_CTRL, ctrl(USE_RED, 1'b1, OFFR_OFF, 4'h1));
		u_src.send_stair(1'b1);
		repeat (4) @(posedge pclk);
		lock_active <= 1'b1;
		repeat (4) @(posedge pclk);
		lvl(8'h64, 1'b0);
		lock_active <= 1'b0;
		repeat (4) @(posedge pclk);
		// mid-run reset from night mode: day again, defaults back
		u_src.send_dn(1'b0);
		repeat (3) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		lvl(8'h00, 1'b0);
		chk({31'h0, night_mode}, 32'h0);
		apb(1'b0, REG_FSTAIR, 32'h0);
		chk(r, FSTAIR_RST);
		// slow switch-on, retriggered delay, slower unlimited orientation, OFF from orientation in two-step option
		apb(1'b1, REG_DELAY, 32'h1);
		apb(1'b1, REG_FOFF, 32'h0);
		apb(1'b1, REG_FSTAIR, 32'h0002_0001);
		apb(1'b1, REG_CTRL, ctrl(USE_RED, 1'b1, OFFR_ORI2, ORI_UNL) | 32'h20);
		u_src.send_stair(1'b1);
		repeat (2000) @(posedge pclk);
		chk({31'h0, (dim_level >= 8'h2C && dim_level <= 8'h3A)}, 32'h1);
		repeat (3000) @(posedge pclk);
		u_src.send_stair(1'b1);
		repeat (6000) @(posedge pclk);
		lvl(8'h64, 1'b1);
		repeat (5000) @(posedge pclk);
		chk({31'h0, (dim_level >= 8'h54 && dim_level <= 8'h5C)}, 32'h1);
		repeat (6000) @(posedge pclk);
		lvl(8'h14, 1'b1);
		repeat (4000) @(posedge pclk);
		lvl(8'h14, 1'b1);
		u_src.send_stair(1'b0);
		repeat (4) @(posedge pclk);
		lvl(8'h00, 1'b0);
		wrap_up();
	end
endmodule
